// ---- include/eirl_pkg.sv ----
// shared constants for the external interrupt request logic
package eirl_pkg;
    // machine cycle of 12 clock periods: six states of two phases
    localparam int          OSC_PER_MCYC   = 12;
    localparam logic [3:0]  TICK_LAST      = 4'h0_00B;
    localparam logic [3:0]  TICK_STATE2_PHASE2      = 4'h0_003;
    localparam logic [3:0]  TICK_POLL      = 4'h0_004;
    localparam logic [3:0]  TICK_STATE5_PHASE2      = 4'h0_009;
    // hardware call occupies two machine cycles
    localparam logic [1:0]  CALL_MCYCLES   = 2'h0_002;
    localparam int          NUM_SRC        = 6;
    localparam int          NUM_EVT        = 6;
    // vectors: 0003H plus eight per source in polling order
    localparam logic [15:0] VEC_BASE       = 16'h0003;
    localparam logic [15:0] VEC_STEP       = 16'h0008;
    // polling order indices
    localparam logic [2:0]  SRC_EXT0       = 3'h0_000;
    localparam logic [2:0]  SRC_TMR0       = 3'h0_001;
    localparam logic [2:0]  SRC_EXT1       = 3'h0_002;
    localparam logic [2:0]  SRC_TMR1       = 3'h0_003;
    // flag register bit positions
    localparam int          FB_EXT0        = 0;
    localparam int          FB_EXT1        = 1;
    localparam int          FB_TMR0        = 2;
    localparam int          FB_TMR1        = 3;
    localparam int          FB_SER_RX      = 4;
    localparam int          FB_SER_TX      = 5;
    localparam int          FB_TMR2_OVF    = 6;
    localparam int          FB_TMR2_EXT    = 7;
    localparam int          EN_GLOBAL      = 7;
    // register byte addresses
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_FLAGS     = 8'h04;
    localparam logic [7:0]  ADDR_ENABLE    = 8'h08;
    localparam logic [7:0]  ADDR_PRIO      = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h14;
    localparam logic [7:0]  ADDR_STATE     = 8'h18;
    // sticky event bits
    localparam int          EV_CALL        = 0;
    localparam int          EV_RETURN      = 1;
    localparam int          EV_EDGE        = 2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0_000;
    localparam logic [1:0]  RESP_SLVERR    = 2'h0_002;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
endpackage

// ---- src/eirl_core.sv ----
// interrupt request front end with axi4-lite registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module eirl_core (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        ext0_request_pin,
    input  wire logic        ext1_request_pin,
    input  wire logic        timer0_overflow_evt,
    input  wire logic        timer1_overflow_evt,
    input  wire logic        timer2_overflow_evt,
    input  wire logic        timer2_external_evt,
    input  wire logic        serial_receive_evt,
    input  wire logic        serial_transmit_evt,
    input  wire logic        instr_final_cycle,
    input  wire logic        instr_is_return_from_interrupt,
    input  wire logic        instr_touches_ie_ip,
    output logic             hardware_long_call,
    output logic [15:0]      call_vector,
    output logic             call_busy,
    output logic             irq
);
    import eirl_pkg::*;

    logic [3:0]  tick;
    logic        at_state2_phase2;
    logic        at_poll;
    logic        at_state5_phase2;
    logic        at_last;

    eirl_timing u_timing (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tick    (tick),
        .at_state2_phase2 (at_state2_phase2),
        .at_poll (at_poll),
        .at_state5_phase2 (at_state5_phase2),
        .at_last (at_last)
    );

    logic [1:0]  sense_reg;
    logic [7:0]  enable_reg;
    logic [5:0]  prio_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    logic [1:0]  ext_flag_reg;
    logic [1:0]  pin_prev_reg;
    logic [5:0]  evt_flag_reg;
    logic [5:0]  evt_pend_reg;
    logic [7:0]  flags;
    logic        in_prog_hi_reg;
    logic        in_prog_lo_reg;
    logic        block_next_reg;
    logic [1:0]  call_cnt_reg;
    logic        call_reg;
    logic [15:0] vector_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // write side: address and data taken independently, then committed
    logic wr_do;
    logic wr_flags;
    logic rd_do;
    logic rd_stat;
    assign s_axi_awready = ce && !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = ce && !w_got_reg && !bvalid_reg;
    assign wr_do    = ce && aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_flags = wr_do && wstrb_reg[0] && (awaddr_reg == ADDR_FLAGS);
    assign s_axi_arready = ce && !rvalid_reg;
    assign rd_do    = s_axi_arvalid && s_axi_arready;
    assign rd_stat  = rd_do && (s_axi_araddr == ADDR_IRQ_STAT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= (awaddr_reg <= ADDR_STATE
                              && awaddr_reg[1:0] == 2'b00)
                              ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // only the low byte lane carries writable register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_reg    <= 2'b00;
            enable_reg   <= RST_BYTE;
            prio_reg     <= 6'h00;
            irq_mask_reg <= 3'h0;
        end else if (wr_do && wstrb_reg[0]) begin
            case (awaddr_reg)
                ADDR_CTRL:     sense_reg    <= wdata_reg[1:0];
                ADDR_ENABLE:   enable_reg   <= wdata_reg[7:0];
                ADDR_PRIO:     prio_reg     <= wdata_reg[5:0];
                ADDR_IRQ_MASK: irq_mask_reg <= wdata_reg[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ce) begin
            if (rd_do) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_CTRL:     rdata_reg <= {30'h0, sense_reg};
                    ADDR_FLAGS:    rdata_reg <= {24'h0, flags};
                    ADDR_ENABLE:   rdata_reg <= {24'h0, enable_reg};
                    ADDR_PRIO:     rdata_reg <= {26'h0, prio_reg};
                    ADDR_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
                    ADDR_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
                    ADDR_STATE:    rdata_reg <= {call_busy, block_next_reg,
                                    in_prog_hi_reg, in_prog_lo_reg,
                                    12'h000, vector_reg};
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // request selection: higher level first, then fixed polling order
    logic [5:0] src_req;
    logic [5:0] hi_req;
    logic [5:0] lo_req;
    logic       grant;
    logic [2:0] grant_idx;
    assign src_req = {flags[FB_TMR2_OVF] | flags[FB_TMR2_EXT],
                      flags[FB_SER_RX] | flags[FB_SER_TX],
                      flags[FB_TMR1], flags[FB_EXT1],
                      flags[FB_TMR0], flags[FB_EXT0]};
    assign hi_req = enable_reg[EN_GLOBAL] ?
                    (src_req & enable_reg[5:0] & prio_reg) : 6'h00;
    assign lo_req = enable_reg[EN_GLOBAL] ?
                    (src_req & enable_reg[5:0] & ~prio_reg) : 6'h00;

    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction

    logic pick_hi;
    logic pick_lo;
    logic instr_blocks;
    // polling happens in state 3, after both flag-setting instants
    assign pick_hi = |hi_req && !in_prog_hi_reg;
    assign pick_lo = |lo_req && !in_prog_hi_reg && !in_prog_lo_reg;
    assign instr_blocks = instr_is_return_from_interrupt || instr_touches_ie_ip;
    assign grant = at_poll && (call_cnt_reg == 2'h0) && instr_final_cycle
                   && !instr_blocks && !block_next_reg
                   && (pick_hi || pick_lo);
    assign grant_idx = pick_hi ? first_set(hi_req) : first_set(lo_req);

    // one further instruction must finish before the next call
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_next_reg <= 1'b0;
        end else if (at_poll && instr_final_cycle) begin
            block_next_reg <= instr_blocks;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_prog_hi_reg <= 1'b0;
            in_prog_lo_reg <= 1'b0;
        end else if (grant) begin
            if (pick_hi) begin
                in_prog_hi_reg <= 1'b1;
            end else begin
                in_prog_lo_reg <= 1'b1;
            end
        end else if (at_poll && instr_final_cycle && instr_is_return_from_interrupt) begin
            // a return closes the innermost level in service
            if (in_prog_hi_reg) begin
                in_prog_hi_reg <= 1'b0;
            end else begin
                in_prog_lo_reg <= 1'b0;
            end
        end
    end

    // the call occupies the rest of this machine cycle and the next one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            call_cnt_reg <= 2'h0;
            call_reg     <= 1'b0;
            vector_reg   <= 16'h0000;
        end else if (ce) begin
            call_reg <= grant;
            if (grant) begin
                call_cnt_reg <= CALL_MCYCLES;
                vector_reg   <= VEC_BASE
                                + ({13'h0, grant_idx} << 3);
            end else if (at_last && call_cnt_reg != 2'h0) begin
                call_cnt_reg <= call_cnt_reg - 2'h1;
            end
        end
    end

    // external flags: pins read only at state5_phase2 of each cycle
    logic [1:0] pins;
    logic [1:0] hw_clr_ext;
    logic [1:0] edge_seen;
    assign pins = {ext1_request_pin, ext0_request_pin};
    assign hw_clr_ext[0] = grant && grant_idx == SRC_EXT0;
    assign hw_clr_ext[1] = grant && grant_idx == SRC_EXT1;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ext
            assign edge_seen[g] = at_state5_phase2 && sense_reg[g]
                                  && pin_prev_reg[g] && !pins[g];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ext_flag_reg[g] <= 1'b0;
                    pin_prev_reg[g] <= 1'b0;
                end else if (ce) begin
                    if (at_state5_phase2) begin
                        pin_prev_reg[g] <= pins[g];
                    end
                    if (at_state5_phase2 && !sense_reg[g]) begin
                        ext_flag_reg[g] <= !pins[g];
                    end else if (edge_seen[g]) begin
                        ext_flag_reg[g] <= 1'b1;
                    end else if (hw_clr_ext[g] && sense_reg[g]) begin
                        ext_flag_reg[g] <= 1'b0;
                    end else if (wr_flags) begin
                        ext_flag_reg[g] <= wdata_reg[g];
                    end
                end
            end
        end
    endgenerate

    // other event flags: pulses held pending until their set instant
    logic [5:0] evt_in;
    logic [5:0] evt_at;
    logic [5:0] hw_clr_evt;
    assign evt_in = {timer2_external_evt, timer2_overflow_evt,
                     serial_transmit_evt, serial_receive_evt,
                     timer1_overflow_evt, timer0_overflow_evt};
    assign evt_at = {at_state5_phase2, at_state2_phase2, at_state5_phase2, at_state5_phase2,
                     at_state5_phase2, at_state5_phase2};
    // timer 0 and timer 1 overflow flags are cleared by the call, the others never
    assign hw_clr_evt = {4'h0, grant && grant_idx == SRC_TMR1,
                         grant && grant_idx == SRC_TMR0};
    generate
        for (g = 0; g < NUM_EVT; g++) begin : g_evt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    evt_pend_reg[g] <= 1'b0;
                    evt_flag_reg[g] <= 1'b0;
                end else if (ce) begin
                    if (evt_at[g]) begin
                        evt_pend_reg[g] <= evt_in[g];
                    end else if (evt_in[g]) begin
                        evt_pend_reg[g] <= 1'b1;
                    end
                    if (evt_at[g] && (evt_pend_reg[g] || evt_in[g])) begin
                        evt_flag_reg[g] <= 1'b1;
                    end else if (hw_clr_evt[g]) begin
                        evt_flag_reg[g] <= 1'b0;
                    end else if (wr_flags) begin
                        evt_flag_reg[g] <= wdata_reg[g + FB_TMR0];
                    end
                end
            end
        end
    endgenerate
    assign flags = {evt_flag_reg, ext_flag_reg};

    // sticky events; a new event beats the clearing read
    logic [2:0] ev_now;
    assign ev_now = {|edge_seen,
                     at_poll && instr_final_cycle && instr_is_return_from_interrupt, grant};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 3'h0;
        end else if (ce) begin
            irq_stat_reg <= (rd_stat ? 3'h0 : irq_stat_reg) | ev_now;
        end
    end

    assign s_axi_bvalid       = bvalid_reg;
    assign s_axi_bresp        = bresp_reg;
    assign s_axi_rvalid       = rvalid_reg;
    assign s_axi_rdata        = rdata_reg;
    assign s_axi_rresp        = rresp_reg;
    assign hardware_long_call = call_reg;
    assign call_vector        = vector_reg;
    assign call_busy          = call_cnt_reg != 2'h0;
    assign irq                = |(irq_stat_reg & irq_mask_reg);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    a_call_at_poll: assert property (grant |-> tick == TICK_POLL)
        else $error("call granted off the polling instant");
    a_call_final: assert property (grant |-> instr_final_cycle)
        else $error("call granted inside an instruction");
    a_block_after: assert property (grant |-> !block_next_reg)
        else $error("call granted right after return or ie/ip access");
    a_equal_level: assert property (grant && !pick_hi |-> !in_prog_lo_reg)
        else $error("call granted during equal level service");
    a_level_follow: assert property (at_state5_phase2 && !sense_reg[0]
        |=> ext_flag_reg[0] == !$past(ext0_request_pin))
        else $error("level flag does not follow pin");
    a_edge_sets: assert property (edge_seen[0] |=> ext_flag_reg[0])
        else $error("falling edge not captured");
    a_edge_clear: assert property (hw_clr_ext[0] && sense_reg[0]
        |=> !ext_flag_reg[0])
        else $error("edge flag not cleared by call");
    a_level_keep: assert property (hw_clr_ext[0] && !sense_reg[0]
        |=> ext_flag_reg[0])
        else $error("level flag cleared by hardware");
    a_tmr2_phase: assert property ($rose(evt_flag_reg[4])
        |-> $past(at_state2_phase2) || $past(wr_flags))
        else $error("timer2 overflow flag set off its phase");
    a_tmr0_phase: assert property ($rose(evt_flag_reg[0])
        |-> $past(at_state5_phase2) || $past(wr_flags))
        else $error("timer0 flag set off its phase");
    a_call_pulse: assert property (grant |=> hardware_long_call
        ##1 (!hardware_long_call && call_busy) [*8])
        else $error("call pulse or busy window wrong");
    a_vec_ext1: assert property (grant && grant_idx == SRC_EXT1
        |=> call_vector == 16'h0013)
        else $error("external 1 vector wrong");
    a_tie_order: assert property (grant && hi_req[0] |-> grant_idx == 3'h0)
        else $error("polling order violated");

    c_edge_call: cover property (edge_seen[0] ##[1:40] grant);
    c_nested: cover property (in_prog_lo_reg && grant && pick_hi);
    c_return_from_interrupt_block: cover property (block_next_reg && at_poll && |src_req);
    c_irq: cover property ($rose(irq));
endmodule

// ---- src/eirl_timing.sv ----
// machine cycle state and phase generator
`timescale 1ns/1ps
module eirl_timing (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    output logic [3:0]      tick,
    output logic            at_state2_phase2,
    output logic            at_poll,
    output logic            at_state5_phase2,
    output logic            at_last
);
    import eirl_pkg::*;

    logic [3:0] tick_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_reg <= 4'h0_000;
        end else if (ce) begin
            if (tick_reg == TICK_LAST) begin
                tick_reg <= 4'h0_000;
            end else begin
                tick_reg <= tick_reg + 4'h0_001;
            end
        end
    end

    assign tick    = tick_reg;
    assign at_state2_phase2 = ce && (tick_reg == TICK_STATE2_PHASE2);
    assign at_poll = ce && (tick_reg == TICK_POLL);
    assign at_state5_phase2 = ce && (tick_reg == TICK_STATE5_PHASE2);
    assign at_last = ce && (tick_reg == TICK_LAST);
endmodule

// ---- verification/eirl_core_bench.sv ----
// self-checking bench for the external interrupt request logic
`timescale 1ns/1ps
module eirl_core_bench;
    import eirl_pkg::*;
    logic        aclk = 0, aresetn = 0, ce = 1;
    logic        awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [5:0]  evt = 0;
    logic        fin = 1, return_from_interrupt = 0, ieip = 0;
    logic [1:0]  rsp;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         call, busy, irq, p0, p1;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [15:0] vec;
    int          n_errors = 0, total_checks = 0, n;

    initial forever #50 aclk = ~aclk;

    eirl_core dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .ext0_request_pin(p0), .ext1_request_pin(p1),
        .timer0_overflow_evt(evt[0]), .timer1_overflow_evt(evt[1]),
        .timer2_overflow_evt(evt[2]), .timer2_external_evt(evt[3]),
        .serial_receive_evt(evt[4]), .serial_transmit_evt(evt[5]),
        .instr_final_cycle(fin), .instr_is_return_from_interrupt(return_from_interrupt),
        .instr_touches_ie_ip(ieip), .hardware_long_call(call),
        .call_vector(vec), .call_busy(busy), .irq(irq));

    eirl_source_model src (.aclk(aclk), .ext0_request_pin(p0),
        .ext1_request_pin(p1));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // handshakes sampled at the falling edge so no race with the slave
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        hb = 0;
        while (!hb) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end
        bready <= 0;
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        logic ha, hr;
        {araddr, arvalid, rready} <= {a, 2'b11};
        hr = 0;
        while (!hr) begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            d = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
        end
        rready <= 0;
        @(posedge aclk);
    endtask

    task automatic wait_call(input int lim);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (call !== 1'b1 && n < lim);
        @(posedge aclk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge aclk);
        n_errors++;
        give_verdict;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int a = 0; a <= 24; a += 4) begin
            rdr(a[7:0], rd);
            cmp(rd, 32'h0000_0000);
        end
        rdr(8'h1c, rd);
        cmp(rd, 32'h0000_0000);
        cmp(rsp, RESP_SLVERR);
        wr(8'h1c, 32'h0000_0001);
        cmp(rsp, RESP_SLVERR);
        // edge mode on ext0: high two machine cycles, then low
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_ENABLE, 32'h0000_0081);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        src.drive(0, 1, 2);
        fork
            src.drive(0, 0, 2);
        join_none
        wait_call(108);
        cmp(n < 108, 1);
        cmp(vec, VEC_BASE);
        cmp(busy, 1);
        rdr(ADDR_FLAGS, rd);
        cmp(rd[FB_EXT0], 0);
        cmp(irq, 1);
        rdr(ADDR_IRQ_STAT, rd);
        cmp(rd[EV_CALL], 1);
        cmp(rd[EV_EDGE], 1);
        cmp(irq, 0);
        // level mode on ext1 stays blocked while ext0 is in service
        wr(ADDR_ENABLE, 32'h0000_0085);
        src.drive(1, 0, 3);
        wait_call(36);
        cmp(n, 36);
        return_from_interrupt <= 1;
        repeat (12) @(posedge aclk);
        return_from_interrupt <= 0;
        wait_call(120);
        cmp(n < 120, 1);
        cmp(vec, VEC_BASE + 2 * VEC_STEP);
        rdr(ADDR_FLAGS, rd);
        cmp(rd[FB_EXT1], 1);
        src.drive(1, 1, 2);
        rdr(ADDR_FLAGS, rd);
        cmp(rd[FB_EXT1], 0);
        // timer and serial events latch at their set instants
        wr(ADDR_ENABLE, 32'h0000_0000);
        evt <= 6'h3f;
        @(posedge aclk);
        evt <= 6'h00;
        repeat (24) @(posedge aclk);
        rdr(ADDR_FLAGS, rd);
        cmp(rd[7:0], 8'hfc);
        give_verdict;
    end
endmodule

// ---- verification/eirl_source_model.sv ----
// external request source driving the two active-low request pins
`timescale 1ns/1ps
module eirl_source_model (
    input  wire logic aclk,
    output logic      ext0_request_pin,
    output logic      ext1_request_pin
);
    // pins idle high, as with the usual pull-up
    logic [1:0] pin_lvl = 2'b11;
    assign ext0_request_pin = pin_lvl[0];
    assign ext1_request_pin = pin_lvl[1];
    // levels held whole machine cycles, or the sample may miss them
    task automatic drive(input int ch, input logic lvl, input int mcyc);
        pin_lvl[ch] <= lvl;
        repeat (12 * mcyc) @(posedge aclk);
    endtask
endmodule
